/* File: inc/ble_regs_pkg.sv */
// Register map, field layout and reset values of the link-layer config bank
// Overview of operation
// [RULE1] Profiling word is 32-bit read/write and drives the diagnostic port
// [RULE2] Radio word 0 bit 22 enables delayed DC path; software keeps it 0
// [RULE3] Software writes 00011 into radio word 1 bits 20:16
// [RULE4] Bits 30:24 hold round-trip delay in microseconds
// [RULE5] Bits 23:16 hold receive power-up time, reset 0xd2
// [RULE6] Bits 11:8 extend transmit power-down time, reset 0x3
// [RULE7] Bits 7:0 hold transmit power-up time, reset 0xd2
// [RULE8] Three-bit channel map, bit i selects channel i+37, reset all on
// [RULE9] Fourteen-bit advertising interval in microseconds
// [RULE10] Bits 24:16 hold the back-off counter load value
// [RULE11] Bits 8:0 hold the active-scan upper limit
// [RULE12] Two 16-bit start pointers for public and private lists
// [RULE13] Count register: private count bits 15:8, public count bits 7:0
// [RULE14] Writing 1 to cipher control bit 0 starts one cipher run
// [RULE15] Start bit clears on the cipher-done event, masked or not
// [RULE16] Four 32-bit read/write words hold the 128-bit cipher key
// [RULE17] Reserved bits read zero and ignore writes; radio word 0 bits 21:0 read 0x2102 instead of zero
`default_nettype none
package ble_regs_pkg;
   localparam logic [31:0] OFS_PROFILING   = 32'h4000_0064;
   localparam logic [31:0] OFS_RADIO0      = 32'h4000_0070;
   localparam logic [31:0] OFS_RADIO1      = 32'h4000_0074;
   localparam logic [31:0] OFS_PWR_TIMING  = 32'h4000_0080;
   localparam logic [31:0] OFS_CHMAP       = 32'h4000_0090;
   localparam logic [31:0] OFS_ADV_INT     = 32'h4000_00a0;
   localparam logic [31:0] OFS_SCAN        = 32'h4000_00a4;
   localparam logic [31:0] OFS_PUB_PTR     = 32'h4000_00b0;
   localparam logic [31:0] OFS_PRIV_PTR    = 32'h4000_00b4;
   localparam logic [31:0] OFS_COUNTS      = 32'h4000_00b8;
   localparam logic [31:0] OFS_CIPHER_CTL  = 32'h4000_00c0;
   localparam logic [31:0] OFS_KEY0        = 32'h4000_00c4;
   localparam logic [31:0] OFS_KEY1        = 32'h4000_00c8;
   localparam logic [31:0] OFS_KEY2        = 32'h4000_00cc;
   localparam logic [31:0] OFS_KEY3        = 32'h4000_00d0;
   localparam logic [31:0] OFS_BLOCK_PTR   = 32'h4000_00d4;

   localparam int DCCOMP_BIT    = 22;
   localparam int XRS_LSB       = 16;
   localparam int XRS_W         = 5;
   localparam int RTD_LSB       = 24;
   localparam int RTD_W         = 7;
   localparam int RXPU_LSB      = 16;
   localparam int RXPU_W        = 8;
   localparam int TXPD_LSB      = 8;
   localparam int TXPD_W        = 4;
   localparam int TXPU_LSB      = 0;
   localparam int TXPU_W        = 8;
   localparam int CHMAP_W       = 3;
   localparam int ADV_INT_W     = 14;
   localparam int SCAN_INIT_LSB = 16;
   localparam int SCAN_W        = 9;
   localparam int PTR_W         = 16;
   localparam int PRIV_CNT_LSB  = 8;
   localparam int CNT_W         = 8;
   localparam int START_BIT     = 0;
   localparam int KEY_WORDS     = 4;

   localparam logic [31:0]       RST_PROFILING = 32'h0;
   localparam logic [21:0]       RADIO0_RSVD   = 22'h2102;
   localparam logic [XRS_W-1:0]  RST_XRS       = 5'h0;
   localparam logic [RTD_W-1:0]  RST_RTD       = 7'h0;
   localparam logic [RXPU_W-1:0] RST_RXPU      = 8'hd2;
   localparam logic [TXPD_W-1:0] RST_TXPD      = 4'h3;
   localparam logic [TXPU_W-1:0] RST_TXPU      = 8'hd2;
   localparam logic [CHMAP_W-1:0] RST_CHMAP    = 3'h7;
endpackage : ble_regs_pkg
`default_nettype wire

/* File: src/cipher_key_store.sv */
// Four-word cipher key store with registered key output
`timescale 1ns/1ps
`default_nettype none
module cipher_key_store (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         wr_en,
   input  wire logic [1:0]   wr_idx,
   input  wire logic [31:0]  wr_data,
   output var  logic [127:0] key
);
   import ble_regs_pkg::*;

   // Word n holds key bits 32n+31 down to 32n
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         key <= 128'h0;
      end else if (wr_en) begin
         for (int i = 0; i < KEY_WORDS; i++) begin
            if (wr_idx == 2'(i)) begin
               key[i*32 +: 32] <= wr_data; // [RULE16]
            end
         end
      end
   end
endmodule : cipher_key_store
`default_nettype wire

/* File: src/ble_config_regs.sv */
// APB register bank for radio, advertising, filter list and cipher settings
`timescale 1ns/1ps
`default_nettype none
module ble_config_regs (
   input  wire logic                      CLK,
   input  wire logic                      RESETN,
   input  wire logic                      PSEL,
   input  wire logic                      PENABLE,
   input  wire logic                      PWRITE,
   input  wire logic [31:0]               PADDR,
   input  wire logic [31:0]               PWDATA,
   output var  logic [31:0]               PRDATA,
   output var  logic                      PREADY,
   output var  logic                      PSLVERR,
   input  wire logic                      CIPHER_DONE_EVENT,
   output var  logic [31:0]               PROFILING_VALUE,
   output var  logic                      DC_COMP_PATH_ENABLE,
   output var  logic [ble_regs_pkg::XRS_W-1:0]    EXTENDED_RADIO_SELECT,
   output var  logic [ble_regs_pkg::RTD_W-1:0]    ROUND_TRIP_DELAY,
   output var  logic [ble_regs_pkg::RXPU_W-1:0]   RX_POWERUP_TIME,
   output var  logic [ble_regs_pkg::TXPD_W-1:0]   TX_POWERDOWN_TIME,
   output var  logic [ble_regs_pkg::TXPU_W-1:0]   TX_POWERUP_TIME,
   output var  logic [ble_regs_pkg::CHMAP_W-1:0]  ADV_CHANNEL_MAP,
   output var  logic [ble_regs_pkg::ADV_INT_W-1:0] ADV_INTERVAL,
   output var  logic [ble_regs_pkg::SCAN_W-1:0]   SCAN_INIT_A,
   output var  logic [ble_regs_pkg::SCAN_W-1:0]   SCAN_UPPER_LIMIT,
   output var  logic [ble_regs_pkg::PTR_W-1:0]    PUBLIC_LIST_START,
   output var  logic [ble_regs_pkg::PTR_W-1:0]    PRIVATE_LIST_START,
   output var  logic [ble_regs_pkg::CNT_W-1:0]    PRIVATE_DEVICE_COUNT,
   output var  logic [ble_regs_pkg::CNT_W-1:0]    PUBLIC_DEVICE_COUNT,
   output var  logic [ble_regs_pkg::PTR_W-1:0]    CIPHER_BLOCK_POINTER,
   output var  logic                      CIPHER_START,
   output var  logic [127:0]              CIPHER_KEY
);
   import ble_regs_pkg::*;

   typedef enum {
      SEL_NONE,
      SEL_PROFILING,
      SEL_RADIO0,
      SEL_RADIO1,
      SEL_PWR_TIMING,
      SEL_CHMAP,
      SEL_ADV_INT,
      SEL_SCAN,
      SEL_PUB_PTR,
      SEL_PRIV_PTR,
      SEL_COUNTS,
      SEL_CIPHER_CTL,
      SEL_KEY0,
      SEL_KEY1,
      SEL_KEY2,
      SEL_KEY3,
      SEL_BLOCK_PTR
   } reg_sel_e;

   // Address decode shared by read and write paths
   function automatic reg_sel_e decode(input logic [31:0] addr);
      reg_sel_e s;
      case (addr)
         OFS_PROFILING:  s = SEL_PROFILING;
         OFS_RADIO0:     s = SEL_RADIO0;
         OFS_RADIO1:     s = SEL_RADIO1;
         OFS_PWR_TIMING: s = SEL_PWR_TIMING;
         OFS_CHMAP:      s = SEL_CHMAP;
         OFS_ADV_INT:    s = SEL_ADV_INT;
         OFS_SCAN:       s = SEL_SCAN;
         OFS_PUB_PTR:    s = SEL_PUB_PTR;
         OFS_PRIV_PTR:   s = SEL_PRIV_PTR;
         OFS_COUNTS:     s = SEL_COUNTS;
         OFS_CIPHER_CTL: s = SEL_CIPHER_CTL;
         OFS_KEY0:       s = SEL_KEY0;
         OFS_KEY1:       s = SEL_KEY1;
         OFS_KEY2:       s = SEL_KEY2;
         OFS_KEY3:       s = SEL_KEY3;
         OFS_BLOCK_PTR:  s = SEL_BLOCK_PTR;
         default:        s = SEL_NONE;
      endcase
      return s;
   endfunction : decode

   reg_sel_e    sel;
   logic        setup;
   logic        wr_go;
   logic        key_wr;
   logic [1:0]  key_idx;
   logic [31:0] rd_word;

   assign sel   = decode(PADDR);
   assign setup = PSEL & ~PENABLE;
   // Writes land only at the access edge where ready is sampled high
   assign wr_go = PSEL & PENABLE & PREADY & PWRITE;

   // No wait state: ready and read data are prepared in the setup cycle
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         PREADY <= 1'b0;
      end else begin
         PREADY <= setup;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         PSLVERR <= 1'b0;
      end else if (setup) begin
         PSLVERR <= (sel == SEL_NONE);
      end else begin
         PSLVERR <= 1'b0;
      end
   end

   // Read mux, unused bit positions return zero, except radio word 0 bits 21:0, which return 0x2102
   always_comb begin
      rd_word = 32'h0;
      case (sel)
         SEL_PROFILING: begin
            rd_word = PROFILING_VALUE;
         end
         SEL_RADIO0: begin
            rd_word[21:0] = RADIO0_RSVD;
            rd_word[DCCOMP_BIT] = DC_COMP_PATH_ENABLE;
         end
         SEL_RADIO1: begin
            rd_word[XRS_LSB +: XRS_W] = EXTENDED_RADIO_SELECT;
         end
         SEL_PWR_TIMING: begin
            rd_word[RTD_LSB +: RTD_W]   = ROUND_TRIP_DELAY;
            rd_word[RXPU_LSB +: RXPU_W] = RX_POWERUP_TIME;
            rd_word[TXPD_LSB +: TXPD_W] = TX_POWERDOWN_TIME;
            rd_word[TXPU_LSB +: TXPU_W] = TX_POWERUP_TIME;
         end
         SEL_CHMAP: begin
            rd_word[CHMAP_W-1:0] = ADV_CHANNEL_MAP;
         end
         SEL_ADV_INT: begin
            rd_word[ADV_INT_W-1:0] = ADV_INTERVAL;
         end
         SEL_SCAN: begin
            rd_word[SCAN_INIT_LSB +: SCAN_W] = SCAN_INIT_A;
            rd_word[SCAN_W-1:0] = SCAN_UPPER_LIMIT;
         end
         SEL_PUB_PTR: begin
            rd_word[PTR_W-1:0] = PUBLIC_LIST_START;
         end
         SEL_PRIV_PTR: begin
            rd_word[PTR_W-1:0] = PRIVATE_LIST_START;
         end
         SEL_COUNTS: begin
            rd_word[PRIV_CNT_LSB +: CNT_W] = PRIVATE_DEVICE_COUNT;
            rd_word[CNT_W-1:0] = PUBLIC_DEVICE_COUNT;
         end
         SEL_CIPHER_CTL: begin
            rd_word[START_BIT] = CIPHER_START;
         end
         SEL_KEY0: begin
            rd_word = CIPHER_KEY[31:0];
         end
         SEL_KEY1: begin
            rd_word = CIPHER_KEY[63:32];
         end
         SEL_KEY2: begin
            rd_word = CIPHER_KEY[95:64];
         end
         SEL_KEY3: begin
            rd_word = CIPHER_KEY[127:96];
         end
         SEL_BLOCK_PTR: begin
            rd_word[PTR_W-1:0] = CIPHER_BLOCK_POINTER;
         end
         default: begin
            rd_word = 32'h0; // [RULE17]
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         PRDATA <= 32'h0;
      end else if (setup && !PWRITE) begin
         PRDATA <= rd_word;
      end else if (!PSEL) begin
         PRDATA <= 32'h0;
      end
   end

   // Profiling word, mirrored straight onto the diagnostic output
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         PROFILING_VALUE <= RST_PROFILING;
      end else if (wr_go && sel == SEL_PROFILING) begin
         PROFILING_VALUE <= PWDATA; // [RULE1]
      end
   end

   // Radio control word 0, only the DC path enable bit 22 is writable
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         DC_COMP_PATH_ENABLE <= 1'b0;
      end else if (wr_go && sel == SEL_RADIO0) begin
         DC_COMP_PATH_ENABLE <= PWDATA[DCCOMP_BIT]; // [RULE2] [RULE17]
      end
   end

   // Radio control word 1, value is stored as written
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         EXTENDED_RADIO_SELECT <= RST_XRS;
      end else if (wr_go && sel == SEL_RADIO1) begin
         EXTENDED_RADIO_SELECT <= PWDATA[XRS_LSB +: XRS_W];
      end
   end

   // Radio power timing fields
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ROUND_TRIP_DELAY  <= RST_RTD;
         RX_POWERUP_TIME   <= RST_RXPU;
         TX_POWERDOWN_TIME <= RST_TXPD;
         TX_POWERUP_TIME   <= RST_TXPU;
      end else if (wr_go && sel == SEL_PWR_TIMING) begin
         ROUND_TRIP_DELAY  <= PWDATA[RTD_LSB +: RTD_W]; // [RULE4]
         RX_POWERUP_TIME   <= PWDATA[RXPU_LSB +: RXPU_W]; // [RULE5]
         TX_POWERDOWN_TIME <= PWDATA[TXPD_LSB +: TXPD_W]; // [RULE6]
         TX_POWERUP_TIME   <= PWDATA[TXPU_LSB +: TXPU_W]; // [RULE7]
      end
   end

   // Advertising channel map, bit i selects channel i plus 37
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ADV_CHANNEL_MAP <= RST_CHMAP;
      end else if (wr_go && sel == SEL_CHMAP) begin
         ADV_CHANNEL_MAP <= PWDATA[CHMAP_W-1:0]; // [RULE8]
      end
   end

   // Advertising packet interval
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ADV_INTERVAL <= '0;
      end else if (wr_go && sel == SEL_ADV_INT) begin
         ADV_INTERVAL <= PWDATA[ADV_INT_W-1:0]; // [RULE9]
      end
   end

   // Active scan back-off load value and upper limit
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         SCAN_INIT_A      <= '0;
         SCAN_UPPER_LIMIT <= '0;
      end else if (wr_go && sel == SEL_SCAN) begin
         SCAN_INIT_A      <= PWDATA[SCAN_INIT_LSB +: SCAN_W]; // [RULE10]
         SCAN_UPPER_LIMIT <= PWDATA[SCAN_W-1:0]; // [RULE11]
      end
   end

   // Filter list start pointers
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         PUBLIC_LIST_START <= '0;
      end else if (wr_go && sel == SEL_PUB_PTR) begin
         PUBLIC_LIST_START <= PWDATA[PTR_W-1:0]; // [RULE12]
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         PRIVATE_LIST_START <= '0;
      end else if (wr_go && sel == SEL_PRIV_PTR) begin
         PRIVATE_LIST_START <= PWDATA[PTR_W-1:0]; // [RULE12]
      end
   end

   // Filter list device counts
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         PRIVATE_DEVICE_COUNT <= '0;
         PUBLIC_DEVICE_COUNT  <= '0;
      end else if (wr_go && sel == SEL_COUNTS) begin
         PRIVATE_DEVICE_COUNT <= PWDATA[PRIV_CNT_LSB +: CNT_W]; // [RULE13]
         PUBLIC_DEVICE_COUNT  <= PWDATA[CNT_W-1:0]; // [RULE13]
      end
   end

   // Cipher block pointer
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         CIPHER_BLOCK_POINTER <= '0;
      end else if (wr_go && sel == SEL_BLOCK_PTR) begin
         CIPHER_BLOCK_POINTER <= PWDATA[PTR_W-1:0];
      end
   end

   // Cipher start: a written 1 wins over a done event in the same cycle
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         CIPHER_START <= 1'b0;
      end else if (wr_go && sel == SEL_CIPHER_CTL && PWDATA[START_BIT]) begin
         CIPHER_START <= 1'b1; // [RULE14]
      end else if (CIPHER_DONE_EVENT) begin
         CIPHER_START <= 1'b0; // [RULE15]
      end
   end

   // Key words go to the key store
   always_comb begin
      key_wr  = 1'b0;
      key_idx = 2'h0;
      case (sel)
         SEL_KEY0: begin
            key_wr  = wr_go;
            key_idx = 2'h0;
         end
         SEL_KEY1: begin
            key_wr  = wr_go;
            key_idx = 2'h1;
         end
         SEL_KEY2: begin
            key_wr  = wr_go;
            key_idx = 2'h2;
         end
         SEL_KEY3: begin
            key_wr  = wr_go;
            key_idx = 2'h3;
         end
         default: begin
            key_wr  = 1'b0;
            key_idx = 2'h0;
         end
      endcase
   end

   cipher_key_store u_key (
      .clk     (CLK),
      .resetn  (RESETN),
      .wr_en   (key_wr), // [RULE16]
      .wr_idx  (key_idx),
      .wr_data (PWDATA),
      .key     (CIPHER_KEY)
   );
endmodule : ble_config_regs
`default_nettype wire

/* File: bench/ble_config_regs_chk.sv */
// Concurrent checks on the ports of the link-layer register bank
`timescale 1ns/1ps
`default_nettype none
module ble_config_regs_chk (
   input wire logic                             CLK,
   input wire logic                             RESETN,
   input wire logic                             PSEL,
   input wire logic                             PENABLE,
   input wire logic                             PWRITE,
   input wire logic [31:0]                      PADDR,
   input wire logic [31:0]                      PWDATA,
   input wire logic [31:0]                      PRDATA,
   input wire logic                             PREADY,
   input wire logic                             PSLVERR,
   input wire logic                             CIPHER_DONE_EVENT,
   input wire logic [31:0]                      PROFILING_VALUE,
   input wire logic [ble_regs_pkg::CHMAP_W-1:0] ADV_CHANNEL_MAP,
   input wire logic [ble_regs_pkg::RXPU_W-1:0]  RX_POWERUP_TIME,
   input wire logic                             CIPHER_START,
   input wire logic [127:0]                     CIPHER_KEY
);
   import ble_regs_pkg::*;
   logic wr_c;
   logic set_c;
   assign wr_c  = PSEL && PENABLE && PREADY && PWRITE;
   assign set_c = wr_c && PADDR == OFS_CIPHER_CTL && PWDATA[START_BIT];
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);
   AST_READY_NEXT: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("ready missing after setup");
   AST_READY_PULSE: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   AST_PROF_WRITE: assert property (wr_c && PADDR == OFS_PROFILING
      |=> PROFILING_VALUE == $past(PWDATA))
      else $error("profiling port not updated");
   AST_CHMAP_WRITE: assert property (wr_c && PADDR == OFS_CHMAP
      |=> ADV_CHANNEL_MAP == $past(PWDATA[2:0]))
      else $error("channel map not updated");
   AST_RXPU_WRITE: assert property (wr_c && PADDR == OFS_PWR_TIMING
      |=> RX_POWERUP_TIME == $past(PWDATA[23:16]))
      else $error("receive power-up time not updated");
   AST_KEY_HIGH: assert property (wr_c && PADDR == OFS_KEY3
      |=> CIPHER_KEY[127:96] == $past(PWDATA))
      else $error("key high word not updated");
   AST_START_SET: assert property (set_c |=> CIPHER_START)
      else $error("start bit not set");
   AST_START_CLEAR: assert property (CIPHER_DONE_EVENT && !set_c
      |=> !CIPHER_START)
      else $error("start bit not cleared on done");
   AST_START_HOLD: assert property (CIPHER_START && !CIPHER_DONE_EVENT
      |=> CIPHER_START)
      else $error("start bit dropped early");
   AST_RADIO0_READ: assert property (PREADY && PSEL && !PWRITE
      && PADDR == OFS_RADIO0 |-> PRDATA[21:0] == RADIO0_RSVD
      && PRDATA[31:23] == 9'h0)
      else $error("radio word 0 fixed bits wrong");
   COV_START: cover property (set_c);
   COV_DONE: cover property (CIPHER_DONE_EVENT && CIPHER_START);
   COV_ERR: cover property (PSLVERR);
   COV_READ: cover property (PREADY && !PWRITE);
   COV_SET_AND_DONE: cover property (set_c && CIPHER_DONE_EVENT);
endmodule : ble_config_regs_chk
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the link-layer register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ble_regs_pkg::*;
   logic          CLK, RESETN, PSEL, PENABLE, PWRITE, CIPHER_DONE_EVENT;
   logic [31:0]   PADDR, PWDATA, PRDATA, PROFILING_VALUE;
   logic          PREADY, PSLVERR, DC_COMP_PATH_ENABLE, CIPHER_START;
   logic [4:0]    EXTENDED_RADIO_SELECT;
   logic [6:0]    ROUND_TRIP_DELAY;
   logic [7:0]    RX_POWERUP_TIME, TX_POWERUP_TIME;
   logic [7:0]    PRIVATE_DEVICE_COUNT, PUBLIC_DEVICE_COUNT;
   logic [3:0]    TX_POWERDOWN_TIME;
   logic [2:0]    ADV_CHANNEL_MAP;
   logic [13:0]   ADV_INTERVAL;
   logic [8:0]    SCAN_INIT_A, SCAN_UPPER_LIMIT;
   logic [15:0]   PUBLIC_LIST_START, PRIVATE_LIST_START, CIPHER_BLOCK_POINTER;
   logic [127:0]  CIPHER_KEY;
   logic [163:0]  ports;
   logic [31:0]   rs, rd;
   logic [31:0]   sh [16];
   logic          err;
   int            failures, cmp_count, i;
   localparam logic [31:0] ADR [16] = '{OFS_PROFILING, OFS_RADIO0,
      OFS_RADIO1, OFS_PWR_TIMING, OFS_CHMAP, OFS_ADV_INT, OFS_SCAN,
      OFS_PUB_PTR, OFS_PRIV_PTR, OFS_COUNTS, OFS_CIPHER_CTL, OFS_KEY0,
      OFS_KEY1, OFS_KEY2, OFS_KEY3, OFS_BLOCK_PTR};
   localparam logic [31:0] MSK [16] = '{32'hffffffff, 32'h00400000,
      32'h001f0000, 32'h7fff0fff, 32'h7, 32'h3fff, 32'h01ff01ff, 32'hffff,
      32'hffff, 32'hffff, 32'h1, 32'hffffffff, 32'hffffffff, 32'hffffffff,
      32'hffffffff, 32'hffff};
   assign ports = {PROFILING_VALUE, DC_COMP_PATH_ENABLE, EXTENDED_RADIO_SELECT,
      ROUND_TRIP_DELAY, RX_POWERUP_TIME, TX_POWERDOWN_TIME, TX_POWERUP_TIME,
      ADV_CHANNEL_MAP, ADV_INTERVAL, SCAN_INIT_A, SCAN_UPPER_LIMIT,
      PUBLIC_LIST_START, PRIVATE_LIST_START, PRIVATE_DEVICE_COUNT,
      PUBLIC_DEVICE_COUNT, CIPHER_BLOCK_POINTER};
   ble_config_regs i_dut (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .CIPHER_DONE_EVENT(CIPHER_DONE_EVENT), .PROFILING_VALUE(PROFILING_VALUE),
      .DC_COMP_PATH_ENABLE(DC_COMP_PATH_ENABLE),
      .EXTENDED_RADIO_SELECT(EXTENDED_RADIO_SELECT),
      .ROUND_TRIP_DELAY(ROUND_TRIP_DELAY), .RX_POWERUP_TIME(RX_POWERUP_TIME),
      .TX_POWERDOWN_TIME(TX_POWERDOWN_TIME), .TX_POWERUP_TIME(TX_POWERUP_TIME),
      .ADV_CHANNEL_MAP(ADV_CHANNEL_MAP), .ADV_INTERVAL(ADV_INTERVAL),
      .SCAN_INIT_A(SCAN_INIT_A), .SCAN_UPPER_LIMIT(SCAN_UPPER_LIMIT),
      .PUBLIC_LIST_START(PUBLIC_LIST_START),
      .PRIVATE_LIST_START(PRIVATE_LIST_START),
      .PRIVATE_DEVICE_COUNT(PRIVATE_DEVICE_COUNT),
      .PUBLIC_DEVICE_COUNT(PUBLIC_DEVICE_COUNT),
      .CIPHER_BLOCK_POINTER(CIPHER_BLOCK_POINTER),
      .CIPHER_START(CIPHER_START), .CIPHER_KEY(CIPHER_KEY));
   initial begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end
   function logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction : xs
   function logic [31:0] exp_rd(input int k);
      return (k == 1) ? sh[1] | 32'h2102 : sh[k];
   endfunction : exp_rd
   function logic [163:0] exp_ports();
      return {sh[0], sh[1][22], sh[2][20:16], sh[3][30:24], sh[3][23:16],
         sh[3][11:8], sh[3][7:0], sh[4][2:0], sh[5][13:0], sh[6][24:16],
         sh[6][8:0], sh[7][15:0], sh[8][15:0], sh[9][15:8], sh[9][7:0],
         sh[15][15:0]};
   endfunction : exp_ports
   task check(input logic [163:0] seen, input logic [163:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task stop_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'b1);
      check(n, 1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb
   task settle;
      @(negedge CLK);
      check(ports, exp_ports());
      check(CIPHER_KEY, {sh[14], sh[13], sh[12], sh[11]});
      check(CIPHER_START, sh[10][0]);
   endtask : settle
   task wr(input int k, input logic [31:0] d);
      apb(1'b1, ADR[k], d);
      check(err, 1'b0);
      if (k == 10)
         sh[10] = sh[10] | (d & 32'h1);
      else
         sh[k] = d & MSK[k];
      settle();
   endtask : wr
   task rdchk(input int k);
      apb(1'b0, ADR[k], 32'h0);
      check(rd, exp_rd(k));
   endtask : rdchk
   task do_reset;
      @(posedge CLK);
      RESETN <= 1'b0;
      foreach (sh[k])
         sh[k] = 32'h0;
      sh[3] = 32'h00d203d2;
      sh[4] = 32'h7;
      repeat (6) @(posedge CLK);
      RESETN <= 1'b1;
      settle();
      for (int k = 0; k < 16; k++)
         rdchk(k);
   endtask : do_reset
   task done_pulse;
      @(posedge CLK);
      CIPHER_DONE_EVENT <= 1'b1;
      @(posedge CLK);
      CIPHER_DONE_EVENT <= 1'b0;
      sh[10] = 32'h0;
      settle();
   endtask : done_pulse
   initial begin
      #100000;
      failures++;
      stop_test();
   end
   initial begin
      rs = 32'd32;
      failures = 0;
      cmp_count = 0;
      {PSEL, PENABLE, PWRITE, CIPHER_DONE_EVENT, RESETN} = 5'h0;
      PADDR = 32'h0;
      PWDATA = 32'h0;
      do_reset();
      for (int k = 0; k < 16; k++) begin
         wr(k, 32'hffffffff);
         rdchk(k);
         wr(k, 32'h0);
         rdchk(k);
      end
      wr(2, 32'h00030000);
      wr(1, 32'h0);
      repeat (60) begin
         i = int'(xs() % 16);
         wr(i, xs());
         rdchk(i);
      end
      apb(1'b1, 32'h4000_0068, xs());
      check(err, 1'b1);
      settle();
      apb(1'b0, 32'h4000_0068, 32'h0);
      check({err, rd}, {1'b1, 32'h0});
      wr(10, 32'h1);
      repeat (3) @(posedge CLK);
      settle();
      done_pulse();
      rdchk(10);
      done_pulse();
      // Start commit and done event in the same cycle: start wins
      fork
         apb(1'b1, OFS_CIPHER_CTL, 32'h1);
         begin
            repeat (2) @(posedge CLK);
            CIPHER_DONE_EVENT <= 1'b1;
            @(posedge CLK);
            CIPHER_DONE_EVENT <= 1'b0;
         end
      join
      check(err, 1'b0);
      sh[10] = 32'h1;
      settle();
      done_pulse();
      rdchk(10);
      do_reset();
      stop_test();
   end
endmodule : testbench
bind ble_config_regs ble_config_regs_chk i_chk (.CLK(CLK), .RESETN(RESETN),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .CIPHER_DONE_EVENT(CIPHER_DONE_EVENT), .PROFILING_VALUE(PROFILING_VALUE),
   .ADV_CHANNEL_MAP(ADV_CHANNEL_MAP), .RX_POWERUP_TIME(RX_POWERUP_TIME),
   .CIPHER_START(CIPHER_START), .CIPHER_KEY(CIPHER_KEY));
`default_nettype wire
